// ---- rtl/flash_front_defines.svh ----
`ifndef FLASH_FRONT_DEFINES_SVH
`define FLASH_FRONT_DEFINES_SVH

`define ADDR_W              21
`define BUSY_CNT_W          23

`define SR_BUSY             0
`define SR_LATCH            1
`define SR_BP_LO            2
`define SR_BP_HI            5
`define SR_AAI              6
`define SR_LOCK             7
`define SR_RESET            8'h1C

`define CMD_STATUS_WRITE    8'h01
`define CMD_STATUS_READ     8'h05

`define SECTOR_BYTES        32'h0000_1000
`define BLOCK32_BYTES       32'h0000_8000
`define BLOCK64_BYTES       32'h0001_0000

`define CLK_PERIOD_NS       8
`define FULL_ERASE_MS       35
`define SECTOR_ERASE_MS     18
`define BYTE_PROGRAM_US     7
`define FULL_ERASE_CYCLES   (`FULL_ERASE_MS * 1000000 / `CLK_PERIOD_NS)
`define SECTOR_ERASE_CYCLES (`SECTOR_ERASE_MS * 1000000 / `CLK_PERIOD_NS)
`define BYTE_PROGRAM_CYCLES (`BYTE_PROGRAM_US * 1000 / `CLK_PERIOD_NS)

`endif

// ---- rtl/flash_front_pkg.sv ----
`include "flash_front_defines.svh"

package flash_front_pkg;

  typedef enum logic [4:0]
  {
    OP_PROGRAM = 5'h01,
    OP_SECTOR  = 5'h02,
    OP_BLOCK32 = 5'h04,
    OP_BLOCK64 = 5'h08,
    OP_FULL    = 5'h10
  } op_kind_type;

  typedef struct packed
  {
    logic              sck;
    logic              cs_n;
    logic              si;
    logic              hold_n;
    logic              wp_n;
  } pin_in_type;

  typedef struct packed
  {
    logic              start;
    op_kind_type       kind;
    logic [`ADDR_W-1:0] addr;
  } op_req_type;

  typedef struct packed
  {
    logic                   selected;
    logic                   paused;
    logic                   out_active;
    logic                   sck_prev;
    logic                   cs_prev;
    logic [2:0]             bit_cnt;
    logic [1:0]             byte_cnt;
    logic [7:0]             cmd;
    logic [7:0]             rx_shift;
    logic [7:0]             tx_shift;
    logic [7:0]             rx_byte;
    logic                   rx_valid;
    logic                   so;
    logic                   so_drive;
    logic [7:0]             status;
    logic                   status_refused;
    logic [`BUSY_CNT_W-1:0] busy_cnt;
    logic [`ADDR_W-1:0]     erase_base;
  } front_state_type;

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pins,
  output      logic [WIDTH-1:0] pins_s
);

  typedef struct packed
  {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_type;

  sync_state_type q;
  sync_state_type d;

  // First stage feeds only the second stage
  always_comb
  begin
    d        = q;
    d.first  = pins;
    d.second = q.first;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{first: {WIDTH{1'b1}}, second: {WIDTH{1'b1}}};
    else
      q <= d;
  end

  assign pins_s = q.second;

endmodule // pin_sync

// ---- rtl/serial_flash_spi_front_end.sv ----
`timescale 1ns/1ps
`include "flash_front_defines.svh"

// Functional notes
// - Command, address and write-data bits are captured on serial clock rising edges.
// - Serial output moves to its next bit on serial clock falling edges.
// - A new command starts only on a high-to-low select transition.
// - Clock idle low (mode 0) and idle high (mode 3) both work.
// - In auto-increment programming the output shows ready/busy while deselected.
// - Pause freezes the serial exchange without losing internal state.
// - Write-guard pin enables or disables the lock-down bit.
// - Erase granularity: 4 KByte sectors, 32 KByte and 64 KByte blocks.
// - Busy flag in status shows an internal write; host polls it.
// - Busy lasts 35 ms full erase, 18 ms sector/block, 7 us byte.
// - Status layout busy/latch/protect[5:2]/auto/lock, power-up value 1Ch.
// - Status write refused only when guard low and lock bit set.
// - Hold pin enters or leaves pause only while the serial clock is low; deselect ends pause at any clock level.
// - Paused output floats; select high during pause resets serial logic.
module serial_flash_spi_front_end #(
  parameter int unsigned FULL_ERASE_CYCLES   = `FULL_ERASE_CYCLES,
  parameter int unsigned SECTOR_ERASE_CYCLES = `SECTOR_ERASE_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire flash_front_pkg::pin_in_type pins,
  output      logic                       so_out,
  output      logic                       so_oe_n,
  input  wire logic [7:0]                 tx_byte,
  input  wire logic                       tx_enable,
  input  wire flash_front_pkg::op_req_type op,
  input  wire logic                       latch_set,
  input  wire logic                       latch_clear,
  input  wire logic                       auto_increment_program,
  output      logic [7:0]                 rx_byte,
  output      logic                       rx_valid,
  output      logic                       selected,
  output      logic [7:0]                 status_reg,
  output      logic                       status_refused,
  output      logic [`ADDR_W-1:0]         erase_base
);

  localparam logic [`BUSY_CNT_W-1:0] PROGRAM_LOAD = `BUSY_CNT_W'(`BYTE_PROGRAM_CYCLES);
  localparam logic [`BUSY_CNT_W-1:0] SECTOR_LOAD  = `BUSY_CNT_W'(SECTOR_ERASE_CYCLES);
  localparam logic [`BUSY_CNT_W-1:0] FULL_LOAD    = `BUSY_CNT_W'(FULL_ERASE_CYCLES);
  localparam logic [`ADDR_W-1:0]     SECTOR_MASK  = ~(`ADDR_W'(`SECTOR_BYTES - 32'h1));
  localparam logic [`ADDR_W-1:0]     BLOCK32_MASK = ~(`ADDR_W'(`BLOCK32_BYTES - 32'h1));
  localparam logic [`ADDR_W-1:0]     BLOCK64_MASK = ~(`ADDR_W'(`BLOCK64_BYTES - 32'h1));

  // Previous-level flags start at the synchroniser's reset level, so no false edge follows reset
  localparam flash_front_pkg::front_state_type STATE_RESET = '{
    sck_prev: 1'b1,
    cs_prev:  1'b1,
    status:   `SR_RESET,
    default:  '0
  };

  flash_front_pkg::pin_in_type     pins_s;
  flash_front_pkg::front_state_type q;
  flash_front_pkg::front_state_type d;
  logic                            sck_rise;
  logic                            sck_fall;
  logic                            wr_guarded;
  logic [7:0]                      sh;
  logic [7:0]                      cmd_now;

  pin_sync #(
    .WIDTH  ($bits(flash_front_pkg::pin_in_type))
  ) u_pin_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pins   (pins),
    .pins_s (pins_s)
  );

  // Edges are found on the synchronised copy, so the link clock must stay well below clk/4
  assign sck_rise   = pins_s.sck & ~q.sck_prev;
  assign sck_fall   = ~pins_s.sck & q.sck_prev;
  assign wr_guarded = ~pins_s.wp_n & q.status[`SR_LOCK];
  assign sh         = {q.rx_shift[6:0], pins_s.si};
  assign cmd_now    = (q.byte_cnt == 2'd0) ? sh : q.cmd;

  always_comb
  begin
    d                = q;
    d.rx_valid       = 1'b0;
    d.status_refused = 1'b0;
    d.sck_prev       = pins_s.sck;
    d.cs_prev        = pins_s.cs_n;

    if (pins_s.cs_n)
    begin
      // Deselect ends any sequence, paused or not
      d.selected   = 1'b0;
      d.paused     = 1'b0;
      d.out_active = 1'b0;
      d.bit_cnt    = 3'd0;
      d.byte_cnt   = 2'd0;
    end
    else if (q.cs_prev)
    begin
      // Only a falling select begins a command
      d.selected   = 1'b1;
      d.paused     = 1'b0;
      d.out_active = 1'b0;
      d.bit_cnt    = 3'd0;
      d.byte_cnt   = 2'd0;
    end
    else if (q.selected)
    begin
      if (!pins_s.sck)
        d.paused = ~pins_s.hold_n;
      // Counters and shifters hold while paused
      if (!q.paused && sck_rise)
      begin
        d.rx_shift = sh;
        d.bit_cnt  = q.bit_cnt + 3'd1;
        if (q.bit_cnt == 3'd7)
        begin
          d.rx_byte  = sh;
          d.rx_valid = 1'b1;
          if (q.byte_cnt != 2'd3)
            d.byte_cnt = q.byte_cnt + 2'd1;
          if (q.byte_cnt == 2'd0)
            d.cmd = sh;
          if ((cmd_now == `CMD_STATUS_READ) || tx_enable)
            d.out_active = 1'b1;
          d.tx_shift = (cmd_now == `CMD_STATUS_READ) ? q.status : tx_byte;
          if ((q.byte_cnt == 2'd1) && (q.cmd == `CMD_STATUS_WRITE))
          begin
            if (wr_guarded)
              d.status_refused = 1'b1;
            else
            begin
              d.status[`SR_BP_HI:`SR_BP_LO] = sh[`SR_BP_HI:`SR_BP_LO];
              d.status[`SR_LOCK]            = sh[`SR_LOCK];
              d.status[`SR_LATCH]           = 1'b0;
            end
          end
        end
      end
      if (!q.paused && sck_fall && q.out_active)
      begin
        d.so       = q.tx_shift[7];
        d.tx_shift = {q.tx_shift[6:0], 1'b0};
      end
    end

    // Internal write timing; a request while busy is dropped
    if (q.busy_cnt != '0)
    begin
      d.busy_cnt = q.busy_cnt - `BUSY_CNT_W'(1);
      if (q.busy_cnt == `BUSY_CNT_W'(1))
        d.status[`SR_LATCH] = 1'b0;
    end
    else if (op.start && q.status[`SR_LATCH])
    begin
      unique case (op.kind)
        flash_front_pkg::OP_PROGRAM:
        begin
          d.busy_cnt   = PROGRAM_LOAD;
          d.erase_base = op.addr;
        end
        flash_front_pkg::OP_SECTOR:
        begin
          d.busy_cnt   = SECTOR_LOAD;
          d.erase_base = op.addr & SECTOR_MASK;
        end
        flash_front_pkg::OP_BLOCK32:
        begin
          d.busy_cnt   = SECTOR_LOAD;
          d.erase_base = op.addr & BLOCK32_MASK;
        end
        flash_front_pkg::OP_BLOCK64:
        begin
          d.busy_cnt   = SECTOR_LOAD;
          d.erase_base = op.addr & BLOCK64_MASK;
        end
        flash_front_pkg::OP_FULL:
        begin
          d.busy_cnt   = FULL_LOAD;
          d.erase_base = '0;
        end
        default:
        begin
          d.busy_cnt   = '0;
        end
      endcase
    end
    d.status[`SR_BUSY] = (d.busy_cnt != '0);
    d.status[`SR_AAI]  = auto_increment_program;

    if (latch_clear)
      d.status[`SR_LATCH] = 1'b0;
    if (latch_set)
      d.status[`SR_LATCH] = 1'b1;

    // Ready/busy replaces data on the output only while deselected
    if (pins_s.cs_n && auto_increment_program)
      d.so = ~q.status[`SR_BUSY];
    d.so_drive = (d.selected & ~d.paused & d.out_active) | (pins_s.cs_n & auto_increment_program);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= STATE_RESET;
    else
      q <= d;
  end

  assign so_out         = q.so;
  assign so_oe_n        = ~q.so_drive;
  assign rx_byte        = q.rx_byte;
  assign rx_valid       = q.rx_valid;
  assign selected       = q.selected;
  assign status_reg     = q.status;
  assign status_refused = q.status_refused;
  assign erase_base     = q.erase_base;

  capture_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.selected && !q.paused && !pins_s.cs_n && !q.cs_prev && sck_rise && q.bit_cnt == 3'd7)
      |=> (q.rx_valid && q.rx_byte == $past(sh)))
    else $error("byte not captured on rising clock");

  shift_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.selected && !q.paused && !pins_s.cs_n && !q.cs_prev && sck_fall && q.out_active)
      |=> (q.so == $past(q.tx_shift[7])))
    else $error("output bit not moved on falling clock");

  select_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(q.selected) |-> $past(q.cs_prev && !pins_s.cs_n))
    else $error("selected without falling select");

  pause_change_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.selected && $past(q.selected) && q.paused != $past(q.paused)) |-> !$past(pins_s.sck))
    else $error("pause changed while clock high");

  pause_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    q.paused |-> !q.so_drive)
    else $error("output driven while paused");

  deselect_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pins_s.cs_n && !auto_increment_program) |=> (!q.so_drive && !q.selected))
    else $error("output driven while deselected");

  ready_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pins_s.cs_n && auto_increment_program) |=> (q.so_drive && q.so == !$past(q.status[`SR_BUSY])))
    else $error("ready/busy not shown on output");

  guard_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.selected && !q.paused && !pins_s.cs_n && !q.cs_prev && sck_rise && q.bit_cnt == 3'd7
      && q.byte_cnt == 2'd1 && q.cmd == `CMD_STATUS_WRITE && wr_guarded)
      |=> (q.status_refused && $stable(q.status[`SR_BP_HI:`SR_BP_LO]) && q.status[`SR_LOCK]))
    else $error("guarded status write not refused");

  program_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.busy_cnt == '0 && op.start && op.kind == flash_front_pkg::OP_PROGRAM && q.status[`SR_LATCH])
      |=> (q.busy_cnt == PROGRAM_LOAD && q.status[`SR_BUSY]))
    else $error("program busy time wrong");

  // Load value plus a strict one-per-cycle countdown fixes the whole busy span
  busy_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (q.busy_cnt != '0)
      |=> (q.busy_cnt == ($past(q.busy_cnt) - `BUSY_CNT_W'(1)) && q.status[`SR_BUSY] == (q.busy_cnt != '0)))
    else $error("busy counter not counting down");

endmodule // serial_flash_spi_front_end

// ---- test/spi_host_model.sv ----
`timescale 1ns/1ps

module spi_host_model (
  input  wire logic                        so_line,
  input  wire logic                        so_oe_n,
  output      flash_front_pkg::pin_in_type pins
);
  logic held_float;

  initial
  begin
    pins = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    held_float = 1'b0;
  end

  // Between frames the clock rests at the level of the chosen mode
  task automatic set_mode(input logic idle_high);
    pins.sck = idle_high;
    #200;
  endtask

  task automatic frame_begin;
    pins.cs_n = 1'b0;
    #40;
  endtask

  task automatic frame_end(input logic idle_high);
    pins.sck = idle_high;
    #62.5;
    pins.cs_n = 1'b1;
    pins.si = ~pins.si;
    #200;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic pause, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      pins.sck = 1'b0;
      pins.si = tx[i];
      #62.5;
      pins.sck = 1'b1;
      rx[i] = so_line;
      #62.5;
      if (pause && i == 4)
      begin
        pins.sck = 1'b0;
        #30;
        // Fall lands well inside clock low so the shift is done before pausing
        pins.hold_n = 1'b0;
        repeat (3)
        begin
          #62.5 pins.sck = 1'b1;
          pins.si = ~pins.si;
          #62.5 pins.sck = 1'b0;
        end
        held_float = so_oe_n;
        pins.hold_n = 1'b1;
        #62.5;
      end
    end
  endtask
endmodule // spi_host_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
  logic                        clk;
  logic                        rst_n;
  flash_front_pkg::pin_in_type pins;
  flash_front_pkg::op_req_type op;
  logic                        so_out;
  logic                        so_oe_n;
  logic                        so_line;
  logic                        latch_set;
  logic                        auto_mode;
  logic                        rx_valid;
  logic                        selected;
  logic                        status_refused;
  logic [7:0]                  rx_byte;
  logic [7:0]                  status_reg;
  logic [7:0]                  rx;
  logic [20:0]                 erase_base;
  int                          error_cnt;
  int                          checks;
  int                          rx_cnt;
  int                          ref_cnt;
  int                          busy_len;
  flash_front_pkg::op_kind_type kinds[5] = '{flash_front_pkg::OP_PROGRAM, flash_front_pkg::OP_SECTOR,
    flash_front_pkg::OP_BLOCK32, flash_front_pkg::OP_BLOCK64, flash_front_pkg::OP_FULL};
  logic [20:0]                 bases[5] = '{21'h1ABCDE, 21'h1AB000, 21'h1A8000, 21'h1A0000, 21'h000000};
  int                          lens[5] = '{875, 50, 50, 50, 100};
  logic [7:0]                  wdat[3] = '{8'h80, 8'h3C, 8'h00};
  logic [7:0]                  wexp[3] = '{8'h80, 8'h80, 8'h00};
  logic [2:0]                  wpv = 3'h5;

  // Floated line rests high through its pull-up
  assign so_line = so_oe_n ? 1'b1 : so_out;

  always #4 clk = ~clk;

  spi_host_model host (.so_line(so_line), .so_oe_n(so_oe_n), .pins(pins));

  serial_flash_spi_front_end #(.FULL_ERASE_CYCLES(100), .SECTOR_ERASE_CYCLES(50)) uut (
    .clk(clk), .rst_n(rst_n), .pins(pins), .so_out(so_out), .so_oe_n(so_oe_n), .tx_byte(8'h00),
    .tx_enable(1'b0), .op(op), .latch_set(latch_set), .latch_clear(1'b0),
    .auto_increment_program(auto_mode), .rx_byte(rx_byte), .rx_valid(rx_valid), .selected(selected),
    .status_reg(status_reg), .status_refused(status_refused), .erase_base(erase_base));

  always @(posedge clk)
  begin
    if (rx_valid === 1'b1) rx_cnt++;
    if (status_refused === 1'b1) ref_cnt++;
    if (status_reg[0] === 1'b1) busy_len++;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmd(input logic mode3, input logic [7:0] b0, input logic [7:0] b1, input logic pause);
    host.set_mode(mode3);
    host.frame_begin();
    chk("selected", 32'h1, selected);
    host.xfer(b0, 1'b0, rx);
    host.xfer(b1, pause, rx);
    host.frame_end(mode3);
  endtask

  task automatic run_op(input int i);
    @(posedge clk) latch_set <= 1'b1;
    @(posedge clk)
    begin
      latch_set <= 1'b0;
      op.start <= 1'b1;
      op.kind <= kinds[i];
      op.addr <= 21'h1ABCDE;
    end
    @(posedge clk) op.start <= 1'b0;
    busy_len = 0;
    repeat (3) @(posedge clk);
    chk("ready_busy_n busy", 32'h0, so_line);
    chk("erase_base", bases[i], erase_base);
    for (int n = 0; n < 1000 && status_reg[0] !== 1'b0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("busy length", lens[i], busy_len);
    chk("ready_busy_n ready", 32'h1, so_line);
    chk("write_latch_bit", 32'h0, status_reg[1]);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    op = '0;
    latch_set = 1'b0;
    auto_mode = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("status reset", 32'h1C, status_reg);
    chk("so_oe_n reset", 32'h1, so_oe_n);
    for (int m = 0; m < 2; m++)
    begin
      cmd(m[0], 8'h05, 8'h00, m[0]);
      chk("status read", 32'h1C, rx);
    end
    chk("paused output", 32'h1, host.held_float);
    repeat (16)
    begin
      host.pins.sck = ~host.pins.sck;
      host.pins.si = ~host.pins.si;
      #62.5;
    end
    chk("bytes received", 32'h4, rx_cnt);
    chk("selected idle", 32'h0, selected);
    $display("test status read done");
    for (int i = 0; i < 3; i++)
    begin
      host.pins.wp_n = wpv[i];
      cmd(i[0], 8'h01, wdat[i], 1'b0);
      repeat (4) @(posedge clk);
      chk("status write", wexp[i], status_reg);
      chk("rx_byte", wdat[i], rx_byte);
    end
    chk("refusals", 32'h1, ref_cnt);
    $display("test status write done");
    auto_mode <= 1'b1;
    @(posedge clk) op.start <= 1'b1;
    op.kind <= flash_front_pkg::OP_SECTOR;
    @(posedge clk) op.start <= 1'b0;
    repeat (3) @(posedge clk);
    chk("busy without latch", 32'h0, status_reg[0]);
    for (int i = 0; i < 5; i++) run_op(i);
    $display("test internal write done");
    close_out();
  end
endmodule // tb_top
